// [design/sac_map.vh]
`ifndef SAC_MAP_VH
`define SAC_MAP_VH

// ----------------------------------------------------------------
// special-function-register addresses
// ----------------------------------------------------------------
`define SAC_ADDR_PAIR_CFG      8'hba
`define SAC_ADDR_CHAN_SEL      8'hbb
`define SAC_ADDR_CONV_CFG      8'hbc
`define SAC_ADDR_RES_LOW       8'hbe
`define SAC_ADDR_RES_HIGH      8'hbf
`define SAC_ADDR_GT_LOW        8'hc4
`define SAC_ADDR_GT_HIGH       8'hc5
`define SAC_ADDR_LT_LOW        8'hc6
`define SAC_ADDR_LT_HIGH       8'hc7
`define SAC_ADDR_CONV_CTRL     8'he8

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define SAC_CTRL_ON_BIT        7
`define SAC_CTRL_TRACK_BIT     6
`define SAC_CTRL_DONE_BIT      5
`define SAC_CTRL_ACTIVE_BIT    4
`define SAC_CTRL_SRC_HI        3
`define SAC_CTRL_SRC_LO        2
`define SAC_CTRL_WIN_BIT       1
`define SAC_CTRL_LEFT_BIT      0

// ----------------------------------------------------------------
// config register fields
// ----------------------------------------------------------------
`define SAC_CFG_DIV_HI         7
`define SAC_CFG_DIV_LO         3
`define SAC_CFG_GAIN_HI        2
`define SAC_CFG_GAIN_LO        0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SAC_RST_CTRL           8'h00
`define SAC_RST_CFG            8'hf8
`define SAC_RST_CHAN_SEL       4'h0
`define SAC_RST_PAIR_CFG       4'h0
`define SAC_RST_GT             16'hffff
`define SAC_RST_LT             16'h0000

// ----------------------------------------------------------------
// start sources and timing counts (in sar clocks)
// ----------------------------------------------------------------
`define SAC_SRC_SOFTWARE       2'h0
`define SAC_SRC_TIMER3         2'h1
`define SAC_SRC_STROBE         2'h2
`define SAC_SRC_TIMER2         2'h3
`define SAC_TRACK_SAR_CLKS     5'h03
`define SAC_CONV_SAR_CLKS      5'h10

`endif

// [design/sac_sar_clkdiv.v]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// sar clock enable divider
// ----------------------------------------------------------------
module sac_sar_clkdiv (
	// clock and reset
	input  wire       i_mclk,
	input  wire       i_rst_n,
	// control
	input  wire       i_run,
	input  wire [4:0] i_div,
	// sar clock enable pulse
	output reg        o_tick
);

	reg  [5:0] cnt_reg;   // system clocks into the sar period
	wire [5:0] last;      // final count of a period

	// period is 2*(div+1) system clocks; div 0 gives one per cycle
	assign last = (i_div == 5'h00) ? 6'h00 : {i_div, 1'b1};

	// counter restarts whenever the converter is idle or off
	always @(posedge i_mclk) begin
		if (!i_rst_n || !i_run) begin
			cnt_reg <= 6'h00;
			o_tick  <= 1'b0;
		end else if (cnt_reg >= last) begin
			cnt_reg <= 6'h00;
			o_tick  <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 6'h01;
			o_tick  <= 1'b0;
		end
	end

endmodule // sac_sar_clkdiv

// [design/sac_window_cmp.v]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// window comparator on the justified result word
// ----------------------------------------------------------------
module sac_window_cmp (
	// operands
	input  wire [15:0] i_word,
	input  wire        i_signed,
	input  wire [15:0] i_gt,
	input  wire [15:0] i_lt,
	// result
	output wire        o_match
);

	// flipping the sign bit lets an unsigned compare order signed words
	function [15:0] bias;
		input [15:0] v;
		input        s;
		begin
			bias = {v[15] ^ s, v[14:0]};
		end
	endfunction

	wire [15:0] w;   // biased data
	wire [15:0] g;   // biased greater-than limit
	wire [15:0] l;   // biased less-than limit

	assign w = bias(i_word, i_signed);
	assign g = bias(i_gt, i_signed);
	assign l = bias(i_lt, i_signed);

	// lt above gt: inside window; otherwise outside window
	assign o_match = (l > g) ? ((w > g) && (w < l))
	                         : ((w < l) || (w > g));

endmodule // sac_window_cmp

// [design/sac_conversion_ctrl.v]
// Contract
// (R01) converter runs only while on bit set
// (R02) off bit means shutdown, no tracking
// (R03) nine channels, ninth is temperature sensor
// (R04) each input pair single or differential
// (R05) reset leaves all inputs single-ended
// (R06) gains 0.5, 2, 4, 8, 16, unity
// (R07) gain resets to one
// (R08) sensor selected feeds the gain stage
// (R09) sar clock divided from system clock
// (R10) conversion rate at most 100 ksps
// (R11) one start source chosen by select
// (R12) active bit high throughout conversion
// (R13) active falling edge sets done flag
// (R14) result justified left or right
// (R15) software clears done, starts, polls, reads
// (R16) track mode zero tracks while idle
// (R17) track mode one tracks three sar clocks
// (R18) strobe mode tracks low, converts rising
// (R19) tracking stops in chip sleep
// (R20) software waits settling after mux change
// (R21) conversion lasts sixteen sar clocks minimum
// (R22) select codes map software, t3, strobe, t2
// (R23) gain code decode table
// (R24) window compare sets window match flag
// (R25) differential results are two's complement
// (R26) off ignores starts, active stays zero
`timescale 1ns/1ps
`include "sac_map.vh"

module sac_conversion_ctrl #(
	parameter RES_BITS = 10
) (
	// clock and reset
	input  wire                i_mclk,
	input  wire                i_rst_n,
	// special-function-register port
	input  wire [7:0]          i_sfr_addr,
	input  wire                i_sfr_wr,
	input  wire                i_sfr_rd,
	input  wire [7:0]          i_sfr_wdata,
	output reg  [7:0]          o_sfr_rdata,
	// start sources and chip sleep
	input  wire                i_timer3_ovf,
	input  wire                i_timer2_ovf,
	input  wire                i_ext_strobe,
	input  wire                i_chip_sleep,
	// analog core
	input  wire [RES_BITS-1:0] i_conv_data,
	output reg                 o_analog_on,
	output reg                 o_track,
	output reg                 o_convert,
	output reg                 o_sar_clk_en,
	output reg  [3:0]          o_chan_addr,
	output reg  [3:0]          o_pair_cfg,
	output reg                 o_temp_sel,
	output reg                 o_diff_sel,
	output reg  [5:0]          o_gain_sel,
	// completion flags
	output reg                 o_done_flag,
	output reg                 o_window_flag
);

	// ------------------------------------------------------------
	// states
	// ------------------------------------------------------------
	localparam ST_IDLE  = 2'h0;   // waiting for a start
	localparam ST_TRACK = 2'h1;   // fixed low-power tracking
	localparam ST_CONV  = 2'h2;   // successive approximation
	localparam ST_DONE  = 2'h3;   // result capture

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	reg        on_reg;            // converter_on_bit
	reg        tm_reg;            // track_mode_select
	reg  [1:0] src_reg;           // start_source_select
	reg        left_reg;          // left_align_select
	reg        done_reg;          // conversion_done_flag
	reg        win_reg;           // window_match_flag
	reg  [7:0] cfg_reg;           // converter_config_reg
	reg  [3:0] chan_reg;          // channel_address_field
	reg  [3:0] pair_reg;          // pair_config_reg
	reg  [15:0] gt_reg;           // greater-than limit word
	reg  [15:0] lt_reg;           // less-than limit word
	reg  [15:0] res_reg;          // justified result word
	reg  [1:0] state_reg;         // sequencer state
	reg  [4:0] cnt_reg;           // sar clocks in this phase
	reg        stb_s1_reg;        // strobe sync stage one
	reg        stb_s2_reg;        // strobe sync stage two
	reg        stb_d_reg;         // strobe delayed for edges

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	// one-hot gain: 1, 2, 4, 8, 16, 0.5 from bit 0 upward
	function [5:0] gain_decode;
		input [2:0] code;
		begin
			case (code)
				3'h0:    gain_decode = 6'h01;
				3'h1:    gain_decode = 6'h02;
				3'h2:    gain_decode = 6'h04;
				3'h3:    gain_decode = 6'h08;
				3'h4,
				3'h5:    gain_decode = 6'h10;
				default: gain_decode = 6'h20;
			endcase
		end
	endfunction

	// true when the channel address picks a differential pair
	function is_diff;
		input [3:0] addr;
		input [3:0] pairs;
		begin
			is_diff = !addr[3] && pairs[addr[2:1]];
		end
	endfunction

	// ------------------------------------------------------------
	// combinational terms
	// ------------------------------------------------------------
	wire        sar_tick;         // one pulse per sar clock
	wire        stb_rise;         // rising edge of synced strobe
	wire        wr_ctrl;          // write to control register
	wire        sw_start;         // software start request
	wire        start_evt;        // selected start event
	wire        strobe_track;     // strobe-gated tracking mode
	wire        diff_now;         // selected channel differential
	wire [15:0] word_next;        // justified form of new data
	wire        win_hit;          // window condition on new data
	wire        finish;           // conversion completes this edge
	wire        busy;             // conversion_active_bit
	wire [1:0]  src_eff;          // source select as of this edge
	wire        tm_eff;           // track mode as of this edge

	// a control write that also sets busy uses its own mode bits,
	// otherwise a start would follow the stale source selection
	assign src_eff  = wr_ctrl ?
		i_sfr_wdata[`SAC_CTRL_SRC_HI:`SAC_CTRL_SRC_LO] : src_reg;
	assign tm_eff   = wr_ctrl ? i_sfr_wdata[`SAC_CTRL_TRACK_BIT] : tm_reg;

	assign busy     = (state_reg != ST_IDLE);   // see (R12)
	assign wr_ctrl  = i_sfr_wr && (i_sfr_addr == `SAC_ADDR_CONV_CTRL);
	assign sw_start = wr_ctrl && i_sfr_wdata[`SAC_CTRL_ACTIVE_BIT];
	assign stb_rise = stb_s2_reg && !stb_d_reg;
	assign strobe_track = tm_reg && (src_reg == `SAC_SRC_STROBE);

	// exactly one source counts; others are ignored
	// see (R11) see (R22)
	assign start_evt =
		(src_eff == `SAC_SRC_SOFTWARE) ? sw_start :
		(src_eff == `SAC_SRC_TIMER3)   ? i_timer3_ovf :
		(src_eff == `SAC_SRC_STROBE)   ? stb_rise :
		                                 i_timer2_ovf;

	assign diff_now = is_diff(chan_reg, pair_reg);   // see (R04)

	// differential data arrives two's complement; sign-extend it
	// see (R14) see (R25)
	assign word_next = left_reg ?
		{i_conv_data, {(16-RES_BITS){1'b0}}} :
		{{(16-RES_BITS){diff_now & i_conv_data[RES_BITS-1]}},
		 i_conv_data};

	assign finish = (state_reg == ST_DONE);

	// ------------------------------------------------------------
	// submodules
	// ------------------------------------------------------------
	// sar clock runs only while a timed phase is under way
	sac_sar_clkdiv u_clkdiv (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_run   (on_reg && (state_reg == ST_TRACK ||
		                     state_reg == ST_CONV)),
		.i_div   (cfg_reg[`SAC_CFG_DIV_HI:`SAC_CFG_DIV_LO]),
		.o_tick  (sar_tick)
	);   // see (R09)

	sac_window_cmp u_window (
		.i_word   (word_next),
		.i_signed (diff_now),
		.i_gt     (gt_reg),
		.i_lt     (lt_reg),
		.o_match  (win_hit)
	);

	// ------------------------------------------------------------
	// strobe synchroniser
	// ------------------------------------------------------------
	// pin input; only the second stage and its delayed copy are looked at
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			stb_s1_reg <= 1'b0;
			stb_s2_reg <= 1'b0;
			stb_d_reg  <= 1'b0;
		end else begin
			stb_s1_reg <= i_ext_strobe;
			stb_s2_reg <= stb_s1_reg;
			stb_d_reg  <= stb_s2_reg;
		end
	end

	// ------------------------------------------------------------
	// conversion sequencer
	// ------------------------------------------------------------
	always @(posedge i_mclk) begin
		if (!i_rst_n || !on_reg) begin
			// off: hold idle, drop starts  see (R02) see (R26)
			state_reg <= ST_IDLE;
			cnt_reg   <= 5'h00;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					cnt_reg <= 5'h00;
					if (start_evt) begin
						// strobe edge ends tracking at once  see (R18)
						if (tm_eff && (src_eff != `SAC_SRC_STROBE))
							state_reg <= ST_TRACK;   // see (R17)
						else
							state_reg <= ST_CONV;
					end
				end
				ST_TRACK: begin
					if (sar_tick) begin
						if (cnt_reg == `SAC_TRACK_SAR_CLKS - 5'h01) begin
							cnt_reg   <= 5'h00;
							state_reg <= ST_CONV;
						end else begin
							cnt_reg <= cnt_reg + 5'h01;
						end
					end
				end
				ST_CONV: begin
					// sixteen sar clocks bound the 100 ksps rate
					// see (R21) see (R10)
					if (sar_tick) begin
						if (cnt_reg == `SAC_CONV_SAR_CLKS - 5'h01) begin
							cnt_reg   <= 5'h00;
							state_reg <= ST_DONE;
						end else begin
							cnt_reg <= cnt_reg + 5'h01;
						end
					end
				end
				default: begin
					// capture edge; active bit falls here
					state_reg <= ST_IDLE;
					cnt_reg   <= 5'h00;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// control register and flags
	// ------------------------------------------------------------
	// hardware set beats a software clear in the same cycle
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			on_reg   <= 1'b0;   // control register resets to zero
			tm_reg   <= 1'b0;
			src_reg  <= `SAC_SRC_SOFTWARE;
			left_reg <= 1'b0;
			done_reg <= 1'b0;
			win_reg  <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				on_reg   <= i_sfr_wdata[`SAC_CTRL_ON_BIT];   // see (R01)
				tm_reg   <= i_sfr_wdata[`SAC_CTRL_TRACK_BIT];
				src_reg  <= i_sfr_wdata[`SAC_CTRL_SRC_HI:`SAC_CTRL_SRC_LO];
				left_reg <= i_sfr_wdata[`SAC_CTRL_LEFT_BIT];
			end
			// done set on falling active bit  see (R13)
			done_reg <= finish ||
				(wr_ctrl ? i_sfr_wdata[`SAC_CTRL_DONE_BIT] : done_reg);
			// see (R24)
			win_reg  <= (finish && win_hit) ||
				(wr_ctrl ? i_sfr_wdata[`SAC_CTRL_WIN_BIT] : win_reg);
		end
	end

	// ------------------------------------------------------------
	// configuration, mux and limit registers
	// ------------------------------------------------------------
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			cfg_reg  <= `SAC_RST_CFG;        // gain one  see (R07)
			chan_reg <= `SAC_RST_CHAN_SEL;
			pair_reg <= `SAC_RST_PAIR_CFG;   // see (R05)
			gt_reg   <= `SAC_RST_GT;
			lt_reg   <= `SAC_RST_LT;
		end else if (i_sfr_wr) begin
			// pair config may change mid-run; applies to the result in flight
			case (i_sfr_addr)
				`SAC_ADDR_CONV_CFG: cfg_reg  <= i_sfr_wdata;
				`SAC_ADDR_CHAN_SEL: chan_reg <= i_sfr_wdata[3:0];
				`SAC_ADDR_PAIR_CFG: pair_reg <= i_sfr_wdata[3:0];
				`SAC_ADDR_GT_LOW:   gt_reg[7:0]  <= i_sfr_wdata;
				`SAC_ADDR_GT_HIGH:  gt_reg[15:8] <= i_sfr_wdata;
				`SAC_ADDR_LT_LOW:   lt_reg[7:0]  <= i_sfr_wdata;
				`SAC_ADDR_LT_HIGH:  lt_reg[15:8] <= i_sfr_wdata;
				default:            gt_reg <= gt_reg;
			endcase
		end
	end

	// ------------------------------------------------------------
	// result capture
	// ------------------------------------------------------------
	// result bytes are writable like the other registers
	always @(posedge i_mclk) begin
		if (!i_rst_n)
			res_reg <= 16'h0000;
		else if (finish)
			res_reg <= word_next;   // see (R14)
		else if (i_sfr_wr && i_sfr_addr == `SAC_ADDR_RES_LOW)
			res_reg[7:0] <= i_sfr_wdata;
		else if (i_sfr_wr && i_sfr_addr == `SAC_ADDR_RES_HIGH)
			res_reg[15:8] <= i_sfr_wdata;
	end

	// ------------------------------------------------------------
	// register read port
	// ------------------------------------------------------------
	// one-cycle read latency; unmapped addresses read zero
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_sfr_rdata <= 8'h00;
		end else if (i_sfr_rd) begin
			case (i_sfr_addr)
				`SAC_ADDR_CONV_CTRL: o_sfr_rdata <= {on_reg, tm_reg,
					done_reg, busy, src_reg, win_reg, left_reg};
				`SAC_ADDR_CONV_CFG: o_sfr_rdata <= cfg_reg;
				`SAC_ADDR_CHAN_SEL: o_sfr_rdata <= {4'h0, chan_reg};
				`SAC_ADDR_PAIR_CFG: o_sfr_rdata <= {4'h0, pair_reg};
				`SAC_ADDR_RES_LOW:  o_sfr_rdata <= res_reg[7:0];
				`SAC_ADDR_RES_HIGH: o_sfr_rdata <= res_reg[15:8];
				`SAC_ADDR_GT_LOW:   o_sfr_rdata <= gt_reg[7:0];
				`SAC_ADDR_GT_HIGH:  o_sfr_rdata <= gt_reg[15:8];
				`SAC_ADDR_LT_LOW:   o_sfr_rdata <= lt_reg[7:0];
				`SAC_ADDR_LT_HIGH:  o_sfr_rdata <= lt_reg[15:8];
				default:            o_sfr_rdata <= 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// analog-side outputs
	// ------------------------------------------------------------
	// all registered so the analog core sees glitch-free levels
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_analog_on   <= 1'b0;
			o_track       <= 1'b0;
			o_convert     <= 1'b0;
			o_sar_clk_en  <= 1'b0;
			o_chan_addr   <= `SAC_RST_CHAN_SEL;
			o_pair_cfg    <= `SAC_RST_PAIR_CFG;
			o_temp_sel    <= 1'b0;
			o_diff_sel    <= 1'b0;
			o_gain_sel    <= 6'h01;
			o_done_flag   <= 1'b0;
			o_window_flag <= 1'b0;
		end else begin
			o_analog_on   <= on_reg;   // see (R01)
			// idle tracking depends on mode; sleep stops it
			// see (R16) see (R17) see (R18) see (R19)
			o_track <= on_reg && !i_chip_sleep &&
				(state_reg == ST_TRACK ||
				 (state_reg == ST_IDLE &&
				  (!tm_reg || (strobe_track && !stb_s2_reg))));
			o_convert     <= on_reg && (state_reg == ST_CONV);
			o_sar_clk_en  <= sar_tick;
			o_chan_addr   <= chan_reg;   // see (R03)
			o_pair_cfg    <= pair_reg;
			o_temp_sel    <= chan_reg[3];   // see (R08)
			o_diff_sel    <= diff_now;
			// see (R06) see (R23)
			o_gain_sel    <=
				gain_decode(cfg_reg[`SAC_CFG_GAIN_HI:`SAC_CFG_GAIN_LO]);
			o_done_flag   <= done_reg;
			o_window_flag <= win_reg;
		end
	end

endmodule // sac_conversion_ctrl

// [dv/sac_conversion_ctrl_assertions.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port-level checker for the conversion control block
// ----------------------------------------------------------------
module sac_conversion_ctrl_checker (
	// clock and reset
	input wire       i_mclk,
	input wire       i_rst_n,
	// register port and pins
	input wire [7:0] i_sfr_addr,
	input wire       i_sfr_wr,
	input wire [7:0] i_sfr_wdata,
	input wire       i_chip_sleep,
	// analog core controls and done flag
	input reg        o_analog_on,
	input reg        o_track,
	input reg        o_convert,
	input reg  [3:0] o_chan_addr,
	input reg  [3:0] o_pair_cfg,
	input reg        o_temp_sel,
	input reg        o_diff_sel,
	input reg  [5:0] o_gain_sel,
	input reg        o_done_flag
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	// length of the current conversion phase, saturating
	logic [5:0] conv_cnt;
	always @(posedge i_mclk) begin
		if (!i_rst_n)
			conv_cnt <= 6'h00;
		else if (!o_convert)
			conv_cnt <= 6'h00;
		else if (conv_cnt != 6'h3f)
			conv_cnt <= conv_cnt + 6'h01;
	end

	// one cycle of grace: both outputs are registered
	AST_OFF_IDLE: assert property (!o_analog_on && !$past(o_analog_on)
		|-> !o_track && !o_convert) else $error("busy while off");
	AST_SLEEP: assert property (i_chip_sleep && $past(i_chip_sleep)
		|-> !o_track) else $error("tracking in sleep");
	AST_TRACK_CONV: assert property (!(o_track && o_convert))
		else $error("track and convert together");
	AST_GAIN_ONEHOT: assert property ($onehot(o_gain_sel))
		else $error("gain select not one-hot");
	AST_TEMP_CHAN: assert property (o_temp_sel == o_chan_addr[3])
		else $error("sensor select mismatch");
	AST_DIFF_PAIR: assert property (o_diff_sel |-> !o_chan_addr[3]
		&& o_pair_cfg[o_chan_addr[2:1]]) else $error("bad differential");
	AST_CONV_LEN: assert property ($fell(o_convert) && o_analog_on
		|-> conv_cnt >= 6'd16) else $error("conversion too short");
	AST_DONE_SET: assert property ($fell(o_convert) && o_analog_on
		|-> ##[1:4] o_done_flag) else $error("done flag not set");
	// the flag falls only two cycles after a clearing write
	AST_DONE_HOLD: assert property ($fell(o_done_flag)
		|-> $past(i_sfr_wr, 2) && $past(i_sfr_addr, 2) == 8'he8
		&& !$past(i_sfr_wdata[5], 2)) else $error("done flag lost");
endmodule // sac_conversion_ctrl_checker

// [dv/sac_analog_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// analog inputs and sar core seen from the digital side
// ----------------------------------------------------------------
module sac_analog_model (
	// clock
	input  wire       i_mclk,
	// controls from the block
	input  wire       i_analog_on,
	// level chosen by the bench
	input  wire [9:0] i_level,
	// sar result
	output logic [9:0] o_data
);
	// a powered-down core drives nothing useful: toggle the bits
	initial o_data = 10'h000;
	always @(posedge i_mclk) begin
		if (i_analog_on)
			o_data <= i_level;
		else
			o_data <= ~o_data;
	end
endmodule // sac_analog_model

// [dv/sac_conversion_ctrl_tb.sv]
`timescale 1ns/1ps
module sac_conversion_ctrl_tb;
	logic       i_mclk = 1'b0;   // system clock
	logic       i_rst_n = 1'b0;  // sync reset
	logic [7:0] addr = 8'h00, wdata = 8'h00, rv;
	logic       wr = 1'b0, rd_s = 1'b0, t3 = 1'b0, t2 = 1'b0;
	logic       strobe = 1'b0, sleep = 1'b0;
	logic [9:0] level = 10'h000;     // analog value presented
	wire  [9:0] cdata;
	wire  [7:0] rdata;
	wire        on, track, conv, sen, tsel, dsel, done_f, win_f;
	wire  [3:0] chan, pairs;
	wire  [5:0] gain;
	int         failures = 0, total_checks = 0;
	logic [7:0] ra[11] = '{8'hba, 8'hbb, 8'hbc, 8'hbe, 8'hbf, 8'hc4,
		8'hc5, 8'hc6, 8'hc7, 8'he8, 8'h10};
	logic [7:0] re[11] = '{8'h00, 8'h00, 8'hf8, 8'h00, 8'h00, 8'hff,
		8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] ge[8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h10,
		8'h20, 8'h20};

	always #20 i_mclk = ~i_mclk;

	sac_conversion_ctrl dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
		.i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd_s),
		.i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_timer3_ovf(t3),
		.i_timer2_ovf(t2), .i_ext_strobe(strobe), .i_chip_sleep(sleep),
		.i_conv_data(cdata), .o_analog_on(on), .o_track(track),
		.o_convert(conv), .o_sar_clk_en(sen), .o_chan_addr(chan),
		.o_pair_cfg(pairs), .o_temp_sel(tsel), .o_diff_sel(dsel),
		.o_gain_sel(gain), .o_done_flag(done_f), .o_window_flag(win_f));
	sac_analog_model ana_u (.i_mclk(i_mclk), .i_analog_on(on),
		.i_level(level), .o_data(cdata));

	// ----------------------------------------------------------------
	// register port, start pin and tally tasks and comparisons
	// ----------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge i_mclk);
		wr <= 1'b0;
	endtask
	// read data lands on the taking edge, sampled a cycle later
	task automatic rreg(input logic [7:0] a);
		@(posedge i_mclk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge i_mclk);
		rd_s <= 1'b0;
		@(posedge i_mclk);
		#1 rv = rdata;
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h",
				$time, got, exp);
		end
	endtask
	task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
		rreg(a);
		cmp(rv, exp);
	endtask
	// polls the done flag as software would, bounded
	task automatic poll_done;
		int n;
		n = 0;
		rreg(8'he8);
		while (rv[5] !== 1'b1 && n < 100) begin
			rreg(8'he8);
			n++;
		end
		cmp({7'h00, rv[5]}, 8'h01);
	endtask
	task automatic fire(input int s);
		@(posedge i_mclk);
		if (s == 1) t3 <= 1'b1;
		if (s == 3) t2 <= 1'b1;
		if (s == 2) strobe <= 1'b1;
		@(posedge i_mclk);
		t3 <= 1'b0;
		t2 <= 1'b0;
		cyc(4);
		strobe <= 1'b0;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		int trk;
		cyc(20);
		i_rst_n <= 1'b1;
		for (int k = 0; k < 11; k++) chk_reg(ra[k], re[k]);
		cmp({2'b00, gain}, 8'h01);
		wreg(8'hc6, 8'h5a);
		wreg(8'hc7, 8'ha5);
		chk_reg(8'hc6, 8'h5a);
		chk_reg(8'hc7, 8'ha5);
		for (int g = 0; g < 8; g++) begin
			wreg(8'hbc, {5'h00, g[2:0]});
			cyc(2);
			cmp({2'b00, gain}, ge[g]);
		end
		// starts while off are refused
		wreg(8'he8, 8'h10);
		fire(1);
		chk_reg(8'he8, 8'h00);
		wreg(8'hbb, 8'h08);
		cyc(2);
		cmp({3'h0, tsel, chan}, 8'h18);
		wreg(8'hbb, 8'h00);
		wreg(8'hbc, 8'h00);
		wreg(8'he8, 8'h80);
		cyc(2);
		cmp({7'h00, track}, 8'h01);
		sleep <= 1'b1;
		cyc(3);
		cmp({7'h00, track}, 8'h00);
		sleep <= 1'b0;
		cyc(38);   // mux settling before any start
		level <= 10'h2a5;
		wreg(8'he8, 8'h90);
		poll_done;
		chk_reg(8'hbf, 8'h02);
		chk_reg(8'hbe, 8'ha5);
		chk_reg(8'he8, 8'ha2);
		cmp({7'h00, win_f}, 8'h01);
		wreg(8'hc7, 8'h00);
		wreg(8'hc6, 8'h10);
		wreg(8'he8, 8'h90);
		poll_done;
		chk_reg(8'he8, 8'ha0);
		wreg(8'he8, 8'h91);
		poll_done;
		chk_reg(8'hbf, 8'ha9);
		chk_reg(8'hbe, 8'h40);
		wreg(8'hba, 8'h01);
		cyc(38);
		cmp({7'h00, dsel}, 8'h01);
		level <= 10'h3f0;
		wreg(8'he8, 8'h90);
		poll_done;
		chk_reg(8'hbf, 8'hff);
		chk_reg(8'hbe, 8'hf0);
		wreg(8'hba, 8'h00);
		for (int s = 1; s < 4; s++) begin
			wreg(8'he8, 8'h80 | (s << 2));
			fire((s % 3) + 1);
			chk_reg(8'he8, 8'h80 | (s << 2));
			fire(s);
			poll_done;
		end
		// low-power tracking, sar clock of four system clocks
		wreg(8'hbc, 8'h08);
		wreg(8'he8, 8'hd0);
		trk = 0;
		for (int i = 0; i < 40; i++) begin
			@(posedge i_mclk);
			if (track === 1'b1) trk++;
		end
		cmp({7'h00, trk >= 12 && trk <= 14}, 8'h01);
		poll_done;
		wreg(8'he8, 8'hc8);
		cyc(6);
		cmp({7'h00, track}, 8'h01);
		strobe <= 1'b1;   // rising edge starts the conversion
		cyc(6);
		cmp({7'h00, track}, 8'h00);
		poll_done;
		strobe <= 1'b0;
		// switching off mid-conversion aborts without a done flag
		wreg(8'he8, 8'h90);
		cyc(4);
		wreg(8'he8, 8'h00);
		cyc(2);
		chk_reg(8'he8, 8'h00);
		tally_and_finish;
	end

	// watchdog well beyond the several hundred cycles of the run
	initial begin
		cyc(30000);
		failures++;
		tally_and_finish;
	end
endmodule // sac_conversion_ctrl_tb

bind sac_conversion_ctrl sac_conversion_ctrl_checker chk_u (.i_mclk,
	.i_rst_n, .i_sfr_addr, .i_sfr_wr, .i_sfr_wdata, .i_chip_sleep,
	.o_analog_on, .o_track, .o_convert, .o_chan_addr, .o_pair_cfg,
	.o_temp_sel, .o_diff_sel, .o_gain_sel, .o_done_flag);
